//--- logic/irs_pkg.sv
package irs_pkg;

  // Eight pin bits for each of the seven ports, index 0 is port A
  typedef logic [6:0][7:0] irs_port_bytes_t;

  // One host bus cycle presented to the register window
  typedef struct packed {
    logic sel;          // Window select from the host decoder
    logic wr;           // Write strobe, one cycle
    logic rd;           // Read strobe, one cycle
    logic [15:0] addr;  // Host address
    logic [7:0] wdata;  // Write data
  } irs_bus_req_t;

  // Window size and offset width
  localparam int unsigned WINDOW_BYTES = 256;
  localparam int unsigned OFS_W = 8;

  // Per-port register offsets, index 6 is port G
  localparam irs_port_bytes_t OFS_PIN_IN = {8'h41, 8'h40, 8'h30, 8'h11, 8'h10, 8'h01, 8'h00};
  localparam irs_port_bytes_t OFS_LATCH = {8'h45, 8'h44, 8'h34, 8'h15, 8'h14, 8'h05, 8'h04};
  localparam irs_port_bytes_t OFS_DIR = {8'h47, 8'h46, 8'h36, 8'h17, 8'h16, 8'h07, 8'h06};
  localparam irs_port_bytes_t OFS_DRIVE = {8'h49, 8'h48, 8'h38, 8'h19, 8'h18, 8'h09, 8'h08};
  localparam irs_port_bytes_t OFS_MODE = {8'h43, 8'h42, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam irs_port_bytes_t OFS_INCELL = {8'h00, 8'h00, 8'h00, 8'h1A, 8'h00, 8'h0B, 8'h0A};
  localparam irs_port_bytes_t OFS_OESTAT = {8'h00, 8'h4C, 8'h00, 8'h00, 8'h1C, 8'h0D, 8'h0C};

  // Which ports carry which register, bit 0 is port A
  localparam logic [6:0] HAS_MODE = 7'h70;
  localparam logic [6:0] HAS_INCELL = 7'h0B;
  localparam logic [6:0] HAS_OESTAT = 7'h27;
  localparam logic [6:0] HAS_OPEN_DRAIN = 7'h5B;

  // Other register offsets
  localparam logic [7:0] OFS_CELLS_A = 8'h20;
  localparam logic [7:0] OFS_CELLS_B = 8'h21;
  localparam logic [7:0] OFS_MASK_A = 8'h22;
  localparam logic [7:0] OFS_MASK_B = 8'h23;
  localparam logic [7:0] OFS_POWER_0 = 8'hB0;
  localparam logic [7:0] OFS_POWER_2 = 8'hB4;
  localparam logic [7:0] OFS_PRIMARY_PROT = 8'hC0;
  localparam logic [7:0] OFS_SECONDARY_PROT = 8'hC2;
  localparam logic [7:0] OFS_TEST_PORT = 8'hC7;
  localparam logic [7:0] OFS_PAGE = 8'hE0;
  localparam logic [7:0] OFS_MAPPING = 8'hE2;
  localparam logic [7:0] OFS_MAIN_SIZE = 8'hF0;
  localparam logic [7:0] OFS_SECOND_TYPE = 8'hF1;

  // Field positions in the secondary protection register
  localparam int unsigned SEC_SECURITY_BIT = 7;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam irs_port_bytes_t RST_PORTS = '0;

endpackage : irs_pkg

//--- logic/irs_io_register_space.sv
`timescale 1ns/1ps
module irs_io_register_space #(
  parameter logic [7:0] MAIN_MEMORY_SIZE_CODE = 8'h00,   // Arbitrary value
  parameter logic [7:0] SECOND_MEMORY_TYPE_CODE = 8'h00  // Arbitrary value
) (
  input wire logic clk_i,                                     // Clock, 125 MHz
  input wire logic reset_n_i,                                 // Async reset, low
  input wire irs_pkg::irs_bus_req_t bus_i,                    // Host bus cycle
  input wire logic [7:0] window_base_i,                       // Window base, high byte
  output logic [7:0] rdata_o,                                 // Read data, registered
  output logic rvalid_o,                                      // Read data valid pulse
  input wire irs_pkg::irs_port_bytes_t pin_i,                 // Pin levels in
  output irs_pkg::irs_port_bytes_t pin_o,                     // Pin drive levels
  output irs_pkg::irs_port_bytes_t pin_oe_o,                  // Pin drive enables
  output logic [1:0][7:0] pin_slew_o,                         // Slew select, C then F
  input wire logic [2:0][7:0] latched_addr_i,                 // Latched address, E,F,G
  input wire irs_pkg::irs_port_bytes_t input_cell_i,          // Input cell states
  output logic [1:0][7:0] output_cell_o,                      // Output cells, A then B
  input wire logic [7:0] primary_prot_i,                      // Primary sector protect
  input wire logic [3:0] secondary_prot_i,                    // Secondary sector protect
  input wire logic security_i,                                // Security bit set
  output logic [7:0] power_control_0_o,                       // Power control 0
  output logic [7:0] power_control_2_o,                       // Power control 2
  output logic [7:0] test_port_enable_o,                      // Test port enable
  output logic [7:0] address_page_o,                          // Page value
  output logic [7:0] memory_space_mapping_o                   // Memory mapping
);
  import irs_pkg::*;

  irs_port_bytes_t latch;        // Output latches
  irs_port_bytes_t dir;          // Direction bits
  irs_port_bytes_t drive;        // Drive select bits
  irs_port_bytes_t mode;         // Mode control bits
  logic [1:0][7:0] mask;         // Output cell write masks
  logic hit;                     // Access falls in the window
  logic wr_hit;                  // Write inside the window
  logic [7:0] ofs;               // Offset within window
  logic [7:0] next_rdata;        // Read value for this offset
  irs_port_bytes_t next_pin;     // Computed pin levels
  irs_port_bytes_t next_oe;      // Computed pin enables

  // Write strobe for a given offset
  function automatic logic wr_at(input logic [7:0] o);
    wr_at = wr_hit && (ofs == o);
  endfunction : wr_at

  // Window decode: select plus matching base
  assign hit = bus_i.sel && (bus_i.addr[15:8] == window_base_i);
  assign wr_hit = hit && bus_i.wr;
  assign ofs = bus_i.addr[OFS_W-1:0];

  // Per-port configuration registers
  genvar p;
  generate
    for (p = 0; p < 7; p++) begin : g_port
      // Output latch
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          latch[p] <= RST_BYTE;
        end else if (wr_at(OFS_LATCH[p])) begin
          latch[p] <= bus_i.wdata;
        end
      end
      // Direction
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          dir[p] <= RST_BYTE;
        end else if (wr_at(OFS_DIR[p])) begin
          dir[p] <= bus_i.wdata;
        end
      end
      // Drive select
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          drive[p] <= RST_BYTE;
        end else if (wr_at(OFS_DRIVE[p])) begin
          drive[p] <= bus_i.wdata;
        end
      end
    end
  endgenerate

  // Mode control; one process owns the whole array so ports without it get no second driver
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode <= RST_PORTS;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (HAS_MODE[i] && wr_at(OFS_MODE[i])) begin
          mode[i] <= bus_i.wdata;
        end
      end
    end
  end

  // Pin drive computation per pin
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (mode[i][b]) begin
          // Address out mode drives the latched address bit
          next_pin[i][b] = latched_addr_i[(i >= 4) ? i - 4 : 0][b];
          next_oe[i][b] = 1'b1;
        end else if (!dir[i][b]) begin
          // Input: released
          next_pin[i][b] = 1'b0;
          next_oe[i][b] = 1'b0;
        end else if (HAS_OPEN_DRAIN[i] && drive[i][b]) begin
          // Open drain: low only, released on a 1
          next_pin[i][b] = 1'b0;
          next_oe[i][b] = !latch[i][b];
        end else begin
          // Push-pull
          next_pin[i][b] = latch[i][b];
          next_oe[i][b] = 1'b1;
        end
      end
    end
  end

  // Registered pin drive
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_o <= RST_PORTS;
      pin_oe_o <= RST_PORTS;
    end else begin
      pin_o <= next_pin;
      pin_oe_o <= next_oe;
    end
  end

  // Slew selects on C and F follow their drive registers
  assign pin_slew_o = {drive[5], drive[2]};

  // Output cells and their masks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask <= '0;
    end else begin
      if (wr_at(OFS_MASK_A)) begin
        mask[0] <= bus_i.wdata;
      end
      if (wr_at(OFS_MASK_B)) begin
        mask[1] <= bus_i.wdata;
      end
    end
  end

  // Masked bits keep their value on a host load
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      output_cell_o <= '0;
    end else begin
      if (wr_at(OFS_CELLS_A)) begin
        output_cell_o[0] <= (bus_i.wdata & ~mask[0]) | (output_cell_o[0] & mask[0]);
      end
      if (wr_at(OFS_CELLS_B)) begin
        output_cell_o[1] <= (bus_i.wdata & ~mask[1]) | (output_cell_o[1] & mask[1]);
      end
    end
  end

  // Miscellaneous control registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_control_0_o <= RST_BYTE;
      power_control_2_o <= RST_BYTE;
      test_port_enable_o <= RST_BYTE;
      address_page_o <= RST_BYTE;
      memory_space_mapping_o <= RST_BYTE;
    end else begin
      if (wr_at(OFS_POWER_0)) begin
        power_control_0_o <= bus_i.wdata;
      end
      if (wr_at(OFS_POWER_2)) begin
        power_control_2_o <= bus_i.wdata;
      end
      if (wr_at(OFS_TEST_PORT)) begin
        test_port_enable_o <= bus_i.wdata;
      end
      if (wr_at(OFS_PAGE)) begin
        address_page_o <= bus_i.wdata;
      end
      if (wr_at(OFS_MAPPING)) begin
        memory_space_mapping_o <= bus_i.wdata;
      end
    end
  end

  // Read decode; unassigned offsets fall through to zero
  always_comb begin
    next_rdata = RST_BYTE;
    for (int i = 0; i < 7; i++) begin
      if (ofs == OFS_PIN_IN[i]) begin
        next_rdata = pin_i[i];
      end
      if (ofs == OFS_LATCH[i]) begin
        next_rdata = latch[i];
      end
      if (ofs == OFS_DIR[i]) begin
        next_rdata = dir[i];
      end
      if (ofs == OFS_DRIVE[i]) begin
        next_rdata = drive[i];
      end
      if (HAS_MODE[i] && ofs == OFS_MODE[i]) begin
        next_rdata = mode[i];
      end
      if (HAS_INCELL[i] && ofs == OFS_INCELL[i]) begin
        next_rdata = input_cell_i[i];
      end
      if (HAS_OESTAT[i] && ofs == OFS_OESTAT[i]) begin
        next_rdata = pin_oe_o[i];
      end
    end
    case (ofs)
      OFS_CELLS_A: next_rdata = output_cell_o[0];
      OFS_CELLS_B: next_rdata = output_cell_o[1];
      OFS_MASK_A: next_rdata = mask[0];
      OFS_MASK_B: next_rdata = mask[1];
      OFS_POWER_0: next_rdata = power_control_0_o;
      OFS_POWER_2: next_rdata = power_control_2_o;
      OFS_PRIMARY_PROT: next_rdata = primary_prot_i;
      OFS_SECONDARY_PROT: next_rdata = {security_i, 3'h0, secondary_prot_i};
      OFS_TEST_PORT: next_rdata = test_port_enable_o;
      OFS_PAGE: next_rdata = address_page_o;
      OFS_MAPPING: next_rdata = memory_space_mapping_o;
      OFS_MAIN_SIZE: next_rdata = MAIN_MEMORY_SIZE_CODE;
      OFS_SECOND_TYPE: next_rdata = SECOND_MEMORY_TYPE_CODE;
      default: ;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= RST_BYTE;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= hit && bus_i.rd;
      if (hit && bus_i.rd) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // Checks on the window behaviour
  a_window_miss: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_i.rd && !hit |=> !rvalid_o) else $error("Read outside window answered");
  a_pin_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_PIN_IN[0] |=> rdata_o == $past(pin_i[0]))
    else $error("Port A pin read wrong");
  a_latch_drive: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    dir[0][7] && !drive[0][7] ##1 dir[0][7] && !drive[0][7]
    |-> pin_o[0][7] == $past(latch[0][7]) && pin_oe_o[0][7])
    else $error("Push-pull pin wrong");
  a_input_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !dir[3][2] && !mode[3][2] |=> !pin_oe_o[3][2]) else $error("Input pin driven");
  a_addr_mode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode[4][1] |=> pin_oe_o[4][1] && pin_o[4][1] == $past(latched_addr_i[0][1]))
    else $error("Address out wrong");
  a_open_drain: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    dir[0][3] && drive[0][3] && !mode[0][3]
    |=> !pin_o[0][3] && pin_oe_o[0][3] == !$past(latch[0][3]))
    else $error("Open drain wrong");
  a_slew_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    dir[2][0] && drive[2][0] |=> pin_oe_o[2][0] && pin_o[2][0] == $past(latch[2][0]))
    else $error("Port C treated as open drain");
  a_oe_status: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_OESTAT[0] |=> rdata_o == $past(pin_oe_o[0]))
    else $error("Enable status wrong");
  a_mask_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_CELLS_A) |=> (output_cell_o[0] & $past(mask[0]))
    == ($past(output_cell_o[0]) & $past(mask[0]))) else $error("Masked cell loaded");
  a_cell_b_mask: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_CELLS_B) |=> (output_cell_o[1] & $past(mask[1]))
    == ($past(output_cell_o[1]) & $past(mask[1]))) else $error("Masked cell B loaded");
  a_mask_allow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_CELLS_A) |=> (output_cell_o[0] & ~$past(mask[0]))
    == ($past(bus_i.wdata) & ~$past(mask[0])))
    else $error("Unmasked cell not loaded");
  a_cell_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_CELLS_B) && mask[1] == 8'h00 |=> output_cell_o[1] == $past(bus_i.wdata))
    else $error("Cell load failed");
  a_sec_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_SECONDARY_PROT |=> rdata_o[SEC_SECURITY_BIT] == $past(security_i)
    && rdata_o[6:4] == 3'h0) else $error("Security read wrong");
  a_hole_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == 8'hFF |=> rdata_o == 8'h00) else $error("Hole not zero");
  a_hole_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == 8'h02 |=> rdata_o == 8'h00)
    else $error("Low hole not zero");

  // Identification, status and control register checks
  a_input_cell: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_INCELL[3] |=> rdata_o == $past(input_cell_i[3]))
    else $error("Input cell read wrong");
  a_prim_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_PRIMARY_PROT |=> rdata_o == $past(primary_prot_i))
    else $error("Primary protection read wrong");
  a_power_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_POWER_2) |=> power_control_2_o == $past(bus_i.wdata))
    else $error("Power control write lost");
  a_map_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_MAPPING) |=> memory_space_mapping_o == $past(bus_i.wdata))
    else $error("Mapping write lost");
  a_main_size: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_MAIN_SIZE |=> rdata_o == MAIN_MEMORY_SIZE_CODE)
    else $error("Main size code wrong");
  a_second_type: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_SECOND_TYPE |=> rdata_o == SECOND_MEMORY_TYPE_CODE)
    else $error("Second type code wrong");

  // Main scenarios worth seeing
  c_pin_read: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    hit && bus_i.rd && ofs == OFS_PIN_IN[6] ##1 rvalid_o);
  c_masked_load: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_CELLS_A) && mask[0] != 8'h00);
  c_open_drain: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    dir[0][0] && drive[0][0] ##1 !pin_oe_o[0][0]);
  c_addr_mode: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_MODE[4]) ##1 mode[4] != 8'h00);
  c_masked_load_b: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_at(OFS_CELLS_B) && mask[1] != 8'h00);

endmodule : irs_io_register_space

//--- tb/irs_host_model.sv
`timescale 1ns/1ps
// Host microcontroller bus master, one byte access at a time
module irs_host_model (
  input wire logic clk_i,              // Bus clock
  input wire logic rvalid_i,           // Read data valid pulse
  input wire logic [7:0] rdata_i,      // Read data
  output irs_pkg::irs_bus_req_t bus_o  // Bus cycle to the window
);
  import irs_pkg::*;

  // Bus idle until the first access
  initial begin
    bus_o = '0;
  end

  // Write cycle, held for exactly the taking edge, then lines turned round
  task automatic bus_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    bus_o <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_i);
    bus_o <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask : bus_write

  // Read cycle, data taken at the edge where the valid pulse is seen
  task automatic bus_read(input logic [15:0] addr, output logic [7:0] data);
    int n;
    @(posedge clk_i);
    bus_o <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_i);
    bus_o <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
    data = 8'hXX;
    // Bounded wait, a missing answer leaves unknown data
    for (n = 0; n < 4; n++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        data = rdata_i;
        break;
      end
    end
  endtask : bus_read

endmodule : irs_host_model

//--- tb/irs_io_register_space_tb_top.sv
`timescale 1ns/1ps
// Register window bench driven through the host bus model
module irs_io_register_space_tb_top;
  import irs_pkg::*;

  logic clk;  // 125 MHz clock
  logic reset_n = 1'b0;  // Async reset, active low
  irs_bus_req_t bus;  // Host bus cycle
  logic [7:0] base, rdata, prim, rd;  // Base, read data, protection, scratch
  logic [7:0] power0, power2, testen, page, mapping;  // Register outputs
  logic rvalid, security;  // Read valid, security level
  irs_port_bytes_t pin_in, pin_out, pin_oe, incell;  // Pin and cell arrays
  logic [1:0][7:0] slew, ocell;  // Slew selects and output cells
  logic [2:0][7:0] laddr;  // Latched address for E, F, G
  logic [3:0] sec;  // Secondary sector protection
  int failures = 0;  // Mismatch count
  int cmp_count = 0;  // Comparison count

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  irs_io_register_space #(.MAIN_MEMORY_SIZE_CODE(8'h3A), .SECOND_MEMORY_TYPE_CODE(8'h4B))
  irs_io_register_space_i (
    .clk_i(clk), .reset_n_i(reset_n), .bus_i(bus), .window_base_i(base), .rdata_o(rdata),
    .rvalid_o(rvalid), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe),
    .pin_slew_o(slew), .latched_addr_i(laddr), .input_cell_i(incell),
    .output_cell_o(ocell), .primary_prot_i(prim), .secondary_prot_i(sec),
    .security_i(security), .power_control_0_o(power0), .power_control_2_o(power2),
    .test_port_enable_o(testen), .address_page_o(page), .memory_space_mapping_o(mapping)
  );

  irs_host_model irs_host_model_i (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .bus_o(bus));

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Read one offset in the window and compare
  task automatic rchk(input string what, input logic [7:0] ofs, input logic [7:0] exp);
    irs_host_model_i.bus_read({base, ofs}, rd);
    check(what, rd, exp);
  endtask : rchk

  // Write one offset in the window
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    irs_host_model_i.bus_write({base, ofs}, d);
  endtask : wr

  // Pins follow configuration one clock after the register
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Verdict and end of run
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // Watchdog against a hung bus
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    complete_run;
  end

  // Main sequence
  initial begin
    base = 8'hC5;
    pin_in = '0;
    incell = '0;
    laddr = '0;
    prim = 8'hC3;
    sec = 4'h5;
    security = 1'b1;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // Reset state, holes and foreign base
    rchk("dir_a", 8'h06, 8'h00);
    check("oe_a_rst", pin_oe[0], 8'h00);
    rchk("hole", 8'h02, 8'h00);
    rchk("hole_ff", 8'hFF, 8'h00);
    irs_host_model_i.bus_write({8'h12, 8'h06}, 8'hFF);
    rchk("dir_a_base", 8'h06, 8'h00);
    // Push-pull outputs on port A
    wr(8'h04, 8'hA5);
    wr(8'h06, 8'hFF);
    settle;
    check("pin_a", pin_out[0], 8'hA5);
    check("oe_a", pin_oe[0], 8'hFF);
    rchk("oe_stat_a", 8'h0C, 8'hFF);
    // Open drain on the low nibble
    wr(8'h08, 8'h0F);
    settle;
    check("pin_a_od", pin_out[0], 8'hA0);
    check("oe_a_od", pin_oe[0], 8'hFA);
    rchk("oe_stat_a_od", 8'h0C, 8'hFA);
    // Port C drive bits pick slew, not open drain
    wr(8'h14, 8'h81);
    wr(8'h16, 8'hFF);
    wr(8'h18, 8'h81);
    settle;
    check("slew_c", slew[0], 8'h81);
    check("slew_f", slew[1], 8'h00);
    check("pin_c", pin_out[2], 8'h81);
    check("oe_c", pin_oe[2], 8'hFF);
    // Live pin levels, input cells and address out mode
    @(posedge clk);
    pin_in[0] <= 8'h3C;
    pin_in[6] <= 8'h81;
    incell[3] <= 8'h66;
    laddr[0] <= 8'h5A;
    rchk("pin_in_a", 8'h00, 8'h3C);
    rchk("pin_in_g", 8'h41, 8'h81);
    rchk("incell_d", 8'h1A, 8'h66);
    wr(8'h32, 8'hFF);
    settle;
    check("pin_e_addr", pin_out[4], 8'h5A);
    check("oe_e_addr", pin_oe[4], 8'hFF);
    // Output cells under the write mask
    wr(8'h22, 8'h0F);
    wr(8'h20, 8'hFF);
    rchk("cells_a", 8'h20, 8'hF0);
    check("cell_out_a", ocell[0], 8'hF0);
    wr(8'h22, 8'h00);
    wr(8'h20, 8'h3C);
    rchk("cells_a2", 8'h20, 8'h3C);
    wr(8'h21, 8'h5A);
    rchk("cells_b", 8'h21, 8'h5A);
    check("cell_out_b", ocell[1], 8'h5A);
    wr(8'h23, 8'hF0);
    wr(8'h21, 8'hFF);
    rchk("mask_b", 8'h23, 8'hF0);
    rchk("cells_b2", 8'h21, 8'h5F);
    // Read-only status and identification
    rchk("prim", 8'hC0, 8'hC3);
    wr(8'hC0, 8'h00);
    rchk("prim_wr", 8'hC0, 8'hC3);
    rchk("second", 8'hC2, 8'h85);
    wr(8'h00, 8'hFF);
    rchk("pin_in_wr", 8'h00, 8'h3C);
    rchk("main_size", 8'hF0, 8'h3A);
    rchk("second_type", 8'hF1, 8'h4B);
    // Power, mapping, page and test port registers
    wr(8'hB0, 8'h12);
    wr(8'hB4, 8'h34);
    wr(8'hE2, 8'h56);
    wr(8'hE0, 8'h78);
    wr(8'hC7, 8'h01);
    rchk("power0", 8'hB0, 8'h12);
    rchk("power2", 8'hB4, 8'h34);
    rchk("mapping", 8'hE2, 8'h56);
    check("power0_o", power0, 8'h12);
    check("power2_o", power2, 8'h34);
    check("mapping_o", mapping, 8'h56);
    check("page_o", page, 8'h78);
    check("testen_o", testen, 8'h01);
    complete_run;
  end

endmodule : irs_io_register_space_tb_top
